// ---- logic/crd_pkg.sv ----
`default_nettype none
package crd_pkg;
    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int INSN_W      = 32;
    localparam int REG_IDX_W   = 5;
    localparam int OP_HI       = 31;
    localparam int OP_LO       = 26;
    localparam int SRC2_HI     = 25;
    localparam int SRC2_LO     = 21;
    localparam int DEST_HI     = 20;
    localparam int DEST_LO     = 16;
    localparam int SRC1_HI     = 15;
    localparam int SRC1_LO     = 11;
    localparam int IMM_W       = 16;
    localparam int OFFS_LOW_W  = 11;
    localparam int BIT_IMM     = 26;
    localparam int BIT_LEN     = 28;
    localparam int BIT_HSEL    = 27;
    localparam int BIT_LS      = 27;
    localparam int BIT_EQ      = 27;
    localparam int ALIGN_BITS  = 2;
    localparam int LATENCY_CYC = 1;

    // ---------------------------------------------------------------
    // Top six opcode bit patterns
    // ---------------------------------------------------------------
    localparam logic [5:0] OPC_IXFR     = 6'h02;
    localparam logic [5:0] OPC_RSVD0    = 6'h06;
    localparam logic [5:0] OPC_FLUSH    = 6'h0d;
    localparam logic [5:0] OPC_PST      = 6'h0f;
    localparam logic [5:0] OPC_CTRL_REG = 6'h0c;
    localparam logic [5:0] OPC_TRAP     = 6'h10;
    localparam logic [5:0] OPC_FP_ESC   = 6'h12;
    localparam logic [5:0] OPC_CORE_ESC = 6'h13;
    localparam logic [5:0] OPC_PFLD     = 6'h19;

    // ---------------------------------------------------------------
    // Control register selectors
    // ---------------------------------------------------------------
    localparam logic [4:0] CR_FAULT     = 5'h00;
    localparam logic [4:0] CR_PSTAT     = 5'h01;
    localparam logic [4:0] CR_DIRBASE   = 5'h02;
    localparam logic [4:0] CR_DBREAK    = 5'h03;
    localparam logic [4:0] CR_FPSTAT    = 5'h04;
    localparam logic [4:0] CR_EXTSTAT   = 5'h05;
    localparam logic [4:0] CR_BUSERR    = 5'h06;
    localparam logic [4:0] CR_CONCUR    = 5'h07;
    localparam logic [4:0] CR_PRIV_ZERO = 5'h08;
    localparam logic [4:0] CR_PRIV_LAST = 5'h0b;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [15:0] {
        GRP_NONE     = 16'h0000,
        GRP_LD_INT   = 16'h0001,
        GRP_ST_INT   = 16'h0002,
        GRP_IXFR     = 16'h0004,
        GRP_FLD      = 16'h0008,
        GRP_FST      = 16'h0010,
        GRP_FLUSH    = 16'h0020,
        GRP_PST      = 16'h0040,
        GRP_CTRL_REG = 16'h0080,
        GRP_TRAP     = 16'h0100,
        GRP_FP_ESC   = 16'h0200,
        GRP_CORE_ESC = 16'h0400,
        GRP_BTE      = 16'h0800,
        GRP_PFLD     = 16'h1000,
        GRP_CTRL_FMT = 16'h2000,
        GRP_ALU      = 16'h4000,
        GRP_ILLEGAL  = 16'h8000
    } crd_group_t;

    typedef enum logic [2:0] {
        SZ_8   = 3'h0,
        SZ_16  = 3'h1,
        SZ_32  = 3'h2,
        SZ_64  = 3'h3,
        SZ_128 = 3'h4
    } crd_size_t;

    typedef struct packed {
        logic        valid;
        crd_group_t  group;
        logic [5:0]  opcode;
        logic [4:0]  src2;
        logic        src2_is_ctrl;
        logic [4:0]  dest;
        logic        dest_is_fp;
        logic [4:0]  src1;
        logic        src1_is_imm;
        logic [31:0] operand_imm;
        logic        high_select;
        logic        is_store;
        logic        branch_on_equal;
        crd_size_t   size;
        logic        autoinc;
        logic        illegal;
    } crd_dec_t;
endpackage
`default_nettype wire

// ---- logic/crd_ctrl_sel.sv ----
`default_nettype none
module crd_ctrl_sel #(
    parameter bit EXTENDED = 1'b1
) (
    // Selector in
    input  wire logic [4:0] i_sel,
    // Verdict out
    output logic            o_defined
);
    // ---------------------------------------------------------------
    // Control register selector check
    // ---------------------------------------------------------------
    // Base variant leaves codes 6..11 undefined; flagging them beats silent misbehaviour
    always_comb
    begin
        if (i_sel <= crd_pkg::CR_EXTSTAT)
            o_defined = 1'b1;
        else if (i_sel <= crd_pkg::CR_PRIV_LAST)
            o_defined = EXTENDED;
        else
            o_defined = 1'b0;
    end
endmodule
`default_nettype wire

// ---- logic/crd_decoder.sv ----
`default_nettype none
module crd_decoder #(
    parameter bit EXTENDED = 1'b1
) (
    // Clock and reset
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst_n,
    // Fetch side
    input  wire logic              i_valid,
    input  wire logic [31:0]       i_insn,
    input  wire logic [31:0]       i_fetch_addr,
    // Datapath side
    output crd_pkg::crd_dec_t      o_dec,
    output logic                   o_misaligned
);
    // ---------------------------------------------------------------
    // Field extraction
    // ---------------------------------------------------------------
    logic [5:0]        op;
    logic [4:0]        f_src2;
    logic [4:0]        f_dest;
    logic [4:0]        f_src1;
    logic [15:0]       f_imm;
    logic              imm_sel;
    logic              ctrl_defined;
    crd_pkg::crd_dec_t dec_next;
    crd_pkg::crd_dec_t dec_reg;
    logic              misaligned_next;
    logic              misaligned_reg;

    assign op      = i_insn[crd_pkg::OP_HI:crd_pkg::OP_LO];
    assign f_src2  = i_insn[crd_pkg::SRC2_HI:crd_pkg::SRC2_LO];
    assign f_dest  = i_insn[crd_pkg::DEST_HI:crd_pkg::DEST_LO];
    assign f_src1  = i_insn[crd_pkg::SRC1_HI:crd_pkg::SRC1_LO];
    assign f_imm   = i_insn[crd_pkg::IMM_W-1:0];
    assign imm_sel = i_insn[crd_pkg::BIT_IMM];

    crd_ctrl_sel #(
        .EXTENDED (EXTENDED)
    ) u_ctrl_sel (
        .i_sel     (f_src2),
        .o_defined (ctrl_defined)
    );

    // ---------------------------------------------------------------
    // Combinational decode
    // ---------------------------------------------------------------
    always_comb
    begin
        dec_next             = '0;
        dec_next.valid       = i_valid;
        dec_next.opcode      = op;
        dec_next.src2        = f_src2;
        dec_next.dest        = f_dest;
        dec_next.src1        = f_src1;
        dec_next.group       = crd_pkg::GRP_NONE;
        dec_next.size        = crd_pkg::SZ_32;
        dec_next.high_select = i_insn[crd_pkg::BIT_HSEL];
        dec_next.src1_is_imm = 1'b0;
        dec_next.operand_imm = {{16{1'b0}}, f_imm};

        // Groups
        casez (op)
            6'b000?01: dec_next.group = crd_pkg::GRP_LD_INT;
            6'b000?11: dec_next.group = crd_pkg::GRP_ST_INT;
            6'b001001: dec_next.group = crd_pkg::GRP_FLD;
            6'b001011: dec_next.group = crd_pkg::GRP_FST;
            6'b0101?1: dec_next.group = crd_pkg::GRP_BTE;
            6'b011???:
            begin
                if (op == crd_pkg::OPC_PFLD)
                    dec_next.group = crd_pkg::GRP_PFLD;
                else
                    dec_next.group = crd_pkg::GRP_CTRL_FMT;
            end
            6'b1?????:
            begin
                // Patterns 11xx10 are reserved
                if (op[5:4] == 2'b11 && op[1:0] == 2'b10)
                    dec_next.group = crd_pkg::GRP_ILLEGAL;
                else
                    dec_next.group = crd_pkg::GRP_ALU;
            end
            default:
            begin
                case (op)
                    crd_pkg::OPC_IXFR:     dec_next.group = crd_pkg::GRP_IXFR;
                    crd_pkg::OPC_FLUSH:    dec_next.group = crd_pkg::GRP_FLUSH;
                    crd_pkg::OPC_PST:      dec_next.group = crd_pkg::GRP_PST;
                    crd_pkg::OPC_CTRL_REG: dec_next.group = crd_pkg::GRP_CTRL_REG;
                    crd_pkg::OPC_TRAP:     dec_next.group = crd_pkg::GRP_TRAP;
                    crd_pkg::OPC_FP_ESC:   dec_next.group = crd_pkg::GRP_FP_ESC;
                    crd_pkg::OPC_CORE_ESC: dec_next.group = crd_pkg::GRP_CORE_ESC;
                    default:               dec_next.group = crd_pkg::GRP_ILLEGAL;
                endcase
            end
        endcase

        dec_next.src2_is_ctrl = (dec_next.group == crd_pkg::GRP_CTRL_REG);
        dec_next.dest_is_fp   = dec_next.group inside {crd_pkg::GRP_FLD, crd_pkg::GRP_FST,
                                    crd_pkg::GRP_PFLD, crd_pkg::GRP_PST, crd_pkg::GRP_IXFR};
        dec_next.is_store     = dec_next.group inside {crd_pkg::GRP_ST_INT, crd_pkg::GRP_FST};
        dec_next.branch_on_equal = (dec_next.group == crd_pkg::GRP_BTE) && i_insn[crd_pkg::BIT_EQ];

        // Source one immediate: only where the encoding allows it
        if (dec_next.group inside {crd_pkg::GRP_LD_INT, crd_pkg::GRP_FLD, crd_pkg::GRP_FST,
                                   crd_pkg::GRP_FLUSH, crd_pkg::GRP_PST, crd_pkg::GRP_PFLD,
                                   crd_pkg::GRP_ALU, crd_pkg::GRP_BTE})
            dec_next.src1_is_imm = imm_sel;

        // Logical ops with high-select apply immediate in the upper half
        if (dec_next.group == crd_pkg::GRP_ALU && op[5:4] == 2'b11 && dec_next.src1_is_imm)
        begin
            if (dec_next.high_select)
                dec_next.operand_imm = {f_imm, {16{1'b0}}};
        end

        // Split offsets replace the plain immediate
        // Loop-branch-add sits among the arithmetic rows, so it is matched by opcode alone
        if (dec_next.group inside {crd_pkg::GRP_ST_INT, crd_pkg::GRP_BTE} || op == 6'h2d)
            dec_next.operand_imm = {{16{f_dest[4]}}, f_dest,
                                    i_insn[crd_pkg::OFFS_LOW_W-1:0]};
        if (dec_next.group == crd_pkg::GRP_BTE && imm_sel)
            dec_next.src1 = f_src1;

        // Integer size and alignment forcing
        if (dec_next.group inside {crd_pkg::GRP_LD_INT, crd_pkg::GRP_ST_INT})
        begin
            if (!i_insn[crd_pkg::BIT_LEN])
                dec_next.size = crd_pkg::SZ_8;
            else if (!i_insn[0])
                dec_next.size = crd_pkg::SZ_16;
            else
                dec_next.size = crd_pkg::SZ_32;
            if (i_insn[crd_pkg::BIT_LEN] && (imm_sel || dec_next.group == crd_pkg::GRP_ST_INT))
                dec_next.operand_imm[0] = 1'b0;
        end

        // Floating memory size, autoincrement and alignment
        if (dec_next.group inside {crd_pkg::GRP_FLD, crd_pkg::GRP_FST, crd_pkg::GRP_PFLD,
                                   crd_pkg::GRP_PST, crd_pkg::GRP_FLUSH})
        begin
            dec_next.autoinc = i_insn[0];
            if (i_insn[1])
                dec_next.size = crd_pkg::SZ_32;
            else if (i_insn[2])
                dec_next.size = crd_pkg::SZ_128;
            else
                dec_next.size = crd_pkg::SZ_64;
            if (dec_next.group == crd_pkg::GRP_FLUSH)
                dec_next.size = crd_pkg::SZ_64;
            if (dec_next.src1_is_imm)
            begin
                dec_next.operand_imm[1:0] = 2'b00;
                if (!i_insn[1])
                    dec_next.operand_imm[2] = 1'b0;
            end
        end

        // Illegal flag: variant-dependent encodings, reserved opcodes, cleared when idle
        if (dec_next.group == crd_pkg::GRP_CTRL_REG && !ctrl_defined)
            dec_next.illegal = 1'b1;
        if (dec_next.group == crd_pkg::GRP_PFLD && !EXTENDED && !i_insn[1] && i_insn[2])
            dec_next.illegal = 1'b1;
        if (dec_next.group == crd_pkg::GRP_ILLEGAL)
            dec_next.illegal = 1'b1;
        if (!i_valid)
            dec_next.illegal = 1'b0;
    end

    // Low address bits must be zero for a word fetch
    assign misaligned_next = i_valid && (i_fetch_addr[crd_pkg::ALIGN_BITS-1:0] != 2'b00);

    // ---------------------------------------------------------------
    // Output registers
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
            dec_reg <= '0;
        else
            dec_reg <= dec_next;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
            misaligned_reg <= 1'b0;
        else
            misaligned_reg <= misaligned_next;
    end

    assign o_dec        = dec_reg;
    assign o_misaligned = misaligned_reg;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    sequence s_wide_int_imm;
        i_valid && !op[5] && !op[4] && !op[3] && op[0] && i_insn[28] && i_insn[26];
    endsequence

    sequence s_fp_mem_imm;
        i_valid && (op == 6'h09 || op == 6'h0b || op == 6'h19 || op == 6'h0f) && i_insn[26];
    endsequence

    sequence s_cmp_branch;
        i_valid && op[5:2] == 4'b0101 && op[0];
    endsequence

    AST_ALIGN: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_valid && i_fetch_addr[1:0] != 2'b00 |=> o_misaligned)
        else $error("misaligned fetch not flagged");
    AST_SRC2: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_valid |=> o_dec.src2 == $past(i_insn[25:21]))
        else $error("src2 field wrong");
    AST_CTRL_SEL: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_valid && op == 6'h0c |=> o_dec.src2_is_ctrl && o_dec.group == crd_pkg::GRP_CTRL_REG)
        else $error("control access not decoded");
    AST_CTRL_UNDEF: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_valid && op == 6'h0c && i_insn[25:21] > 5'h0b |=> o_dec.illegal)
        else $error("unknown control register accepted");
    AST_INT_SIZE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_valid && op[5:3] == 3'b000 && op[0] && !i_insn[28] |=> o_dec.size == crd_pkg::SZ_8)
        else $error("byte size not decoded");
    AST_INT_ALIGN: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        s_wide_int_imm |=> !o_dec.operand_imm[0])
        else $error("integer immediate bit 0 not forced");
    AST_FP_ALIGN: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        s_fp_mem_imm ##0 !i_insn[1] |=> o_dec.operand_imm[2:0] == 3'h0)
        else $error("floating immediate not aligned");
    AST_AUTOINC: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_valid && (op == 6'h0d || op == 6'h0f) |=> o_dec.autoinc == $past(i_insn[0]))
        else $error("autoincrement wrong");
    AST_OFFSET: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_valid && op[5:3] == 3'b000 && op[1:0] == 2'b11
        |=> o_dec.operand_imm[15:1] == $past({i_insn[20:16], i_insn[10:1]}))
        else $error("store offset wrong");
    AST_RSVD: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_valid && op == 6'h06 |=> o_dec.illegal)
        else $error("reserved opcode not flagged");
    AST_DEST_FP: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_valid && op == 6'h02 |=> o_dec.dest_is_fp)
        else $error("ixfr dest not floating");
    AST_CTRL_BASE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_valid && op == 6'h0c && i_insn[25:21] <= 5'h05 |=> !o_dec.illegal)
        else $error("base control register refused");
    AST_OPCODE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_valid |=> o_dec.valid && o_dec.opcode == $past(i_insn[31:26]))
        else $error("opcode field wrong");
    AST_SRC1_IMM: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_valid && op[5:4] == 2'b11 |=> o_dec.src1_is_imm == $past(i_insn[26]))
        else $error("immediate select wrong");
    AST_BTE_SRC1: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        s_cmp_branch |=> o_dec.src1 == $past(i_insn[15:11]) && o_dec.group == crd_pkg::GRP_BTE)
        else $error("compare-branch comparand wrong");
    AST_CTRL_FMT: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_valid && op[5:3] == 3'b011 && op != 6'h19 |=> o_dec.group == crd_pkg::GRP_CTRL_FMT)
        else $error("control-transfer format not decoded");
    AST_FP_SIZE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        s_fp_mem_imm ##0 i_insn[1] |=> o_dec.size == crd_pkg::SZ_32)
        else $error("floating single size wrong");
    AST_PFLD_QUAD: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_valid && op == 6'h19 && !i_insn[1] && i_insn[2] |=> o_dec.illegal == !EXTENDED)
        else $error("quad pipelined load variant wrong");
    AST_HIGH: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_valid && op[5:4] == 2'b11 && op[1:0] == 2'b11
        |=> o_dec.operand_imm == {$past(i_insn[15:0]), 16'h0000})
        else $error("high immediate not shifted");
    AST_BLA: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_valid && op == 6'h2d |=> o_dec.operand_imm[15:0] == $past({i_insn[20:16], i_insn[10:0]}))
        else $error("loop-branch offset wrong");
endmodule
`default_nettype wire

// ---- tb/crd_fetch_model.sv ----
`default_nettype none
module crd_fetch_model (
    // Clock
    input  wire logic        i_clk_sys,
    // Requests from the bench
    input  wire logic        i_req_valid,
    input  wire logic [31:0] i_req_insn,
    input  wire logic [31:0] i_req_addr,
    // Toward the decoder
    output logic             o_valid,
    output logic [31:0]      o_insn,
    output logic [31:0]      o_addr
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Fetch register
    // ----------------------------------------
    // Idle cycles show the inverse of the held word, so stale data is never mistaken for a fresh one
    always_ff @(posedge i_clk_sys)
    begin
        o_valid <= i_req_valid;
        o_insn  <= i_req_valid ? i_req_insn : ~i_req_insn;
        o_addr  <= i_req_valid ? i_req_addr : ~i_req_addr;
        if (i_req_valid && i_req_insn[31:26] == 6'h0d)
        begin
            o_insn[2:1] <= 2'b00;
        end
    end
endmodule
`default_nettype wire

// ---- tb/core_reg_format_decoder_bench.sv ----
`default_nettype none
module core_reg_format_decoder_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic              clk_sys;
    logic              rst_n;
    logic              req_valid;
    logic [31:0]       req_insn;
    logic [31:0]       req_addr;
    logic              f_valid;
    logic [31:0]       f_insn;
    logic [31:0]       f_addr;
    crd_pkg::crd_dec_t dec;
    crd_pkg::crd_dec_t dec_base;
    logic              misaligned;
    int                mismatches;
    int                n_tests;

    crd_fetch_model i_crd_fetch_model (.i_clk_sys(clk_sys), .i_req_valid(req_valid), .i_req_insn(req_insn),
        .i_req_addr(req_addr), .o_valid(f_valid), .o_insn(f_insn), .o_addr(f_addr));
    crd_decoder #(.EXTENDED(1'b1)) i_crd_decoder (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_valid(f_valid),
        .i_insn(f_insn), .i_fetch_addr(f_addr), .o_dec(dec), .o_misaligned(misaligned));
    // Base variant sees the same stream, to judge extended-only encodings
    crd_decoder #(.EXTENDED(1'b0)) i_crd_decoder_base (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_valid(f_valid),
        .i_insn(f_insn), .i_fetch_addr(f_addr), .o_dec(dec_base), .o_misaligned());

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [31:0] mk(input logic [5:0] op, input logic [4:0] s2, input logic [4:0] d,
                                       input logic [15:0] lo);
        return {op, s2, d, lo};
    endfunction

    // Model registers once, decoder once: result settles after the third edge
    task automatic issue(input logic [31:0] insn, input logic [31:0] addr);
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_insn  <= insn;
        req_addr  <= addr;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask

    function automatic crd_pkg::crd_group_t exp_grp(input logic [5:0] op);
        case (op)
            6'h01, 6'h05: return crd_pkg::GRP_LD_INT;
            6'h03, 6'h07: return crd_pkg::GRP_ST_INT;
            6'h02: return crd_pkg::GRP_IXFR;
            6'h09: return crd_pkg::GRP_FLD;
            6'h0b: return crd_pkg::GRP_FST;
            6'h0d: return crd_pkg::GRP_FLUSH;
            6'h0f: return crd_pkg::GRP_PST;
            6'h0c: return crd_pkg::GRP_CTRL_REG;
            6'h10: return crd_pkg::GRP_TRAP;
            6'h12: return crd_pkg::GRP_FP_ESC;
            6'h13: return crd_pkg::GRP_CORE_ESC;
            6'h15, 6'h17: return crd_pkg::GRP_BTE;
            6'h19: return crd_pkg::GRP_PFLD;
            6'h18, 6'h1a, 6'h1b, 6'h1c, 6'h1d, 6'h1e, 6'h1f: return crd_pkg::GRP_CTRL_FMT;
            6'h06, 6'h32, 6'h36, 6'h3a, 6'h3e: return crd_pkg::GRP_ILLEGAL;
            default: return crd_pkg::GRP_NONE;
        endcase
    endfunction

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic s_load_b2b;
        logic [5:0]         op [3] = '{6'h01, 6'h05, 6'h05};
        logic [15:0]        lo [3] = '{16'h1235, 16'h1234, 16'h1235};
        logic [15:0]        im [3] = '{16'h1235, 16'h1234, 16'h1234};
        crd_pkg::crd_size_t sz [3] = '{crd_pkg::SZ_8, crd_pkg::SZ_16, crd_pkg::SZ_32};
        int                 j;
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk_sys);
            req_valid <= (i < 3);
            if (i < 3)
                req_insn <= mk(op[i], 5'h1f, 5'h11, lo[i]);
            #1;
            if (i >= 2)
            begin
                j = i - 2;
                chk("ld group", 32'(crd_pkg::GRP_LD_INT), 32'(dec.group));
                chk("ld size", 32'(sz[j]), 32'(dec.size));
                chk("ld imm", 32'(im[j]), 32'(dec.operand_imm[15:0]));
                chk("ld imm flag", 32'h1, 32'(dec.src1_is_imm));
                chk("ld src2", 32'h1f, 32'(dec.src2));
                chk("ld dest", 32'h11, 32'(dec.dest));
            end
        end
    endtask

    task automatic s_store;
        issue(mk(6'h03, 5'h02, 5'h15, 16'h52a5), 32'h0);
        chk("st group", 32'(crd_pkg::GRP_ST_INT), 32'(dec.group));
        chk("st store", 32'h1, 32'(dec.is_store));
        chk("st offset", {{16{1'b1}}, 5'h15, 11'h2a5}, dec.operand_imm);
        chk("st src1", 32'h0a, 32'(dec.src1));
        chk("st size", 32'(crd_pkg::SZ_8), 32'(dec.size));
        chk("st valid", 32'h1, 32'(dec.valid));
        chk("st dest fp", 32'h0, 32'(dec.dest_is_fp));
        chk("st ctrl", 32'h0, 32'(dec.src2_is_ctrl));
    endtask

    task automatic s_fp_mem;
        logic [15:0] lo;
        for (int b = 0; b < 8; b++)
        begin
            lo = {13'h0b4a, 3'(b)};
            issue(mk((b < 4) ? 6'h09 : 6'h0b, 5'h01, 5'h1e, lo), 32'h0);
            chk("fp size", b[1] ? 32'(crd_pkg::SZ_32) : b[2] ? 32'(crd_pkg::SZ_128) : 32'(crd_pkg::SZ_64),
                32'(dec.size));
            chk("fp autoinc", 32'(b[0]), 32'(dec.autoinc));
            chk("fp imm", 32'({lo[15:3], b[2] & b[1], 2'b00}), 32'(dec.operand_imm[15:0]));
            chk("fp dest fp", 32'h1, 32'(dec.dest_is_fp));
            chk("fp store", 32'(b >= 4), 32'(dec.is_store));
        end
    endtask

    task automatic s_ctrl_pfld;
        for (int c = 0; c < 12; c++)
        begin
            issue(mk(6'h0c, 5'(c), 5'h03, 16'h0), 32'h0);
            chk("cr select", 32'(c), 32'(dec.src2));
            chk("cr flag", 32'h1, 32'(dec.src2_is_ctrl));
            chk("cr ext illegal", 32'h0, 32'(dec.illegal));
            chk("cr base illegal", 32'(c > 5), 32'(dec_base.illegal));
        end
        issue(mk(6'h19, 5'h01, 5'h02, 16'h0004), 32'h0);
        chk("pfld size", 32'(crd_pkg::SZ_128), 32'(dec.size));
        chk("pfld ext illegal", 32'h0, 32'(dec.illegal));
        chk("pfld base illegal", 32'h1, 32'(dec_base.illegal));
    endtask

    task automatic s_groups;
        crd_pkg::crd_group_t g;
        for (int k = 0; k < 64; k++)
        begin
            g = exp_grp(6'(k));
            if (g != crd_pkg::GRP_NONE)
            begin
                issue(mk(6'(k), 5'h0, 5'h0, 16'h0), 32'h0);
                chk("group", 32'(g), 32'(dec.group));
                chk("illegal", 32'(g == crd_pkg::GRP_ILLEGAL), 32'(dec.illegal));
                chk("opcode", 32'(k), 32'(dec.opcode));
                if (g == crd_pkg::GRP_BTE)
                    chk("equal", 32'(k[1]), 32'(dec.branch_on_equal));
            end
        end
    endtask

    task automatic s_imm_branch;
        issue(mk(6'h31, 5'h04, 5'h05, 16'h8421), 32'h0);
        chk("and imm flag", 32'h1, 32'(dec.src1_is_imm));
        chk("and high", 32'h0, 32'(dec.high_select));
        chk("and imm", 32'h8421, 32'(dec.operand_imm[15:0]));
        issue(mk(6'h33, 5'h04, 5'h05, 16'h8421), 32'h0);
        chk("andh imm", 32'h84210000, dec.operand_imm);
        issue(mk(6'h02, 5'h07, 5'h09, 16'h6000), 32'h0);
        chk("ixfr imm flag", 32'h0, 32'(dec.src1_is_imm));
        chk("ixfr src1", 32'h0c, 32'(dec.src1));
        chk("ixfr dest fp", 32'h1, 32'(dec.dest_is_fp));
        issue(mk(6'h17, 5'h06, 5'h13, 16'h7123), 32'h0);
        chk("bte src1", 32'h0e, 32'(dec.src1));
        chk("bte offset", {{16{1'b1}}, 5'h13, 11'h123}, dec.operand_imm);
        issue(mk(6'h2d, 5'h03, 5'h0a, 16'h0456), 32'h0);
        chk("bla offset", 32'h0000_5456, dec.operand_imm);
        issue(mk(6'h0d, 5'h01, 5'h02, 16'h0007), 32'h0);
        chk("flush autoinc", 32'h1, 32'(dec.autoinc));
        chk("flush size", 32'(crd_pkg::SZ_64), 32'(dec.size));
        chk("flush imm", 32'h0, 32'(dec.operand_imm[15:0]));
    endtask

    task automatic s_align;
        for (int a = 0; a < 4; a++)
        begin
            issue(mk(6'h01, 5'h0, 5'h0, 16'h0), {30'h0400, 2'(a)});
            chk("misaligned", 32'(a != 0), 32'(misaligned));
        end
        issue(mk(6'h01, 5'h0, 5'h0, 16'h0), 32'h0000_1003);
        chk("misaligned odd", 32'h1, 32'(misaligned));
        @(posedge clk_sys);
        #1;
        chk("idle valid", 32'h0, 32'(dec.valid));
        chk("idle illegal", 32'h0, 32'(dec.illegal));
        chk("idle misaligned", 32'h0, 32'(misaligned));
    endtask

    // ----------------------------------------
    // Sequence and verdict
    // ----------------------------------------
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        rst_n      = 1'b0;
        req_valid  = 1'b0;
        req_insn   = 32'h0;
        req_addr   = 32'h0;
        mismatches = 0;
        n_tests    = 0;
        repeat (15) @(posedge clk_sys);
        #1;
        chk("reset dec", 32'h0, 32'(dec !== '0));
        chk("reset misaligned", 32'h0, 32'(misaligned));
        @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        s_load_b2b();
        s_store();
        s_fp_mem();
        s_ctrl_pfld();
        s_groups();
        s_imm_branch();
        s_align();
        final_report();
    end

    initial
    begin
        repeat (4000) @(posedge clk_sys);
        mismatches++;
        $display("[ERR] watchdog expected finish seen timeout");
        final_report();
    end
endmodule
`default_nettype wire
